// ===== verilog/d2dini_pkg.sv
// constants and types shared by the die-to-die initiator files
package d2dini_pkg;
    // register offsets
    localparam logic [2:0] REG_CTL0 = 3'h0;
    localparam logic [2:0] REG_CTL1 = 3'h1;
    localparam logic [2:0] REG_ERR = 3'h2;
    localparam logic [2:0] REG_IRQB = 3'h3;
    localparam logic [2:0] REG_ATTR = 3'h4;
    localparam logic [2:0] REG_ADDR = 3'h5;
    localparam logic [2:0] REG_DHI = 3'h6;
    localparam logic [2:0] REG_DLO = 3'h7;
    // link_control_0 fields
    localparam int CTL0_EN = 7;
    localparam int CTL0_CW = 6;
    localparam int CTL0_SWAI = 5;
    localparam int CTL0_DIV = 0;
    // link_control_1 fields
    localparam int CTL1_IE = 7;
    localparam int CTL1_TMO = 0;
    // link_error_status fields
    localparam int ERR_SUM = 7;
    localparam int ERR_ACK = 6;
    localparam int ERR_CNCL = 5;
    localparam int ERR_TIME = 4;
    localparam int ERR_TERR = 3;
    localparam int ERR_PAR = 2;
    // last_xfer_attrs fields
    localparam int ATTR_RNW = 7;
    localparam int ATTR_SZ8 = 6;
    localparam int ATTR_NONBLOCKING_FLAG = 4;
    // reset values
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    // link command beats
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [1:0] CMD_WR = 2'b10;
    localparam logic [1:0] CMD_RD = 2'b11;
    // acknowledge codes on lines 1:0 during the ack beat
    localparam logic [1:0] ACK_WAIT = 2'b00;
    localparam logic [1:0] ACK_OK = 2'b01;
    localparam logic [1:0] ACK_TERR = 2'b10;
    localparam logic [1:0] ACK_BAD = 2'b11;
    // beats per byte on four lines
    localparam logic [2:0] BEATS_NARROW = 3'd2;
    // link sequencer states, gray in declared order; ACK to IDLE changes two bits
    typedef enum logic [2:0] {
        D2DI_IDLE = 3'b000,
        D2DI_CMD = 3'b001,
        D2DI_ADDR = 3'b011,
        D2DI_WDATA = 3'b010,
        D2DI_TURN = 3'b110,
        D2DI_RDATA = 3'b111,
        D2DI_ACK = 3'b101
    } d2dini_state_t;
endpackage : d2dini_pkg

// ===== verilog/d2dini_clkdiv.sv
// link clock divider with clean halt after the high phase
`timescale 1ns/1ps
module d2dini_clkdiv
    import d2dini_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [1:0] div,
    // link clock
    output logic clk_q,
    output logic tick_q
);
    logic [2:0] cnt_q;
    logic [2:0] per;
    logic [2:0] hi;
    logic [2:0] nxt;

    // a flop-driven pin cannot toggle at bus rate, so code 00 runs as code 01
    always_comb begin
        per = (div == 2'b00) ? 3'd2 : 3'({1'b0, div} + 3'd1);
        hi = per >> 1;
        nxt = (cnt_q >= per - 3'd1) ? 3'd0 : 3'(cnt_q + 3'd1);
    end

    // the high phase always runs to its end before the clock parks low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 3'd0;
            clk_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (run || clk_q) begin
            cnt_q <= nxt;
            clk_q <= (nxt < hi) && (run || nxt != 3'd0);
            tick_q <= run && (nxt == 3'd0);
        end else begin
            tick_q <= 1'b0;
        end
    end
endmodule : d2dini_clkdiv

// ===== verilog/d2dini_tmo.sv
// acknowledge timeout counter in link clock periods
`timescale 1ns/1ps
module d2dini_tmo
    import d2dini_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic tick,
    input wire logic [3:0] limit,
    // result
    output logic expired_q
);
    logic [3:0] cnt_q;

    // limit zero disables the timeout
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            cnt_q <= 4'h0;
            expired_q <= 1'b0;
        end else if (tick && limit != 4'h0 && !expired_q) begin
            cnt_q <= 4'(cnt_q + 4'h1);
            expired_q <= (4'(cnt_q + 4'h1) == limit);
        end
    end
endmodule : d2dini_tmo

// ===== verilog/d2dini_top.sv
// die-to-die initiator: registers, window decode and link sequencer
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module d2dini_top
    import d2dini_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // window access port
    input wire logic win_wr,
    input wire logic win_rd,
    input wire logic win_nonblock,
    input wire logic win_byte,
    input wire logic [7:0] win_addr,
    input wire logic [15:0] win_wdata,
    output logic [15:0] win_rdata,
    output logic win_done,
    output logic win_stall,
    // system mode
    input wire logic special_mode,
    input wire logic stop_mode,
    // link pins
    output logic link_clock_out,
    output logic [7:0] link_data_out,
    output logic [7:0] link_data_oe,
    output logic [7:0] link_data_pd,
    input wire logic [7:0] link_data_in,
    input wire logic target_irq_in,
    output logic target_irq_pd,
    // interrupts to the cpu
    output logic target_irq_req,
    output logic error_irq
);
    // configuration
    logic [7:0] ctl0_q;
    logic [7:0] ctl1_q;
    logic ctl0_locked_q;
    logic en;
    logic cw;
    // status
    logic [7:0] err_q;
    logic busy_q;
    logic [7:0] attr_q;
    logic [7:0] addr_q;
    logic [15:0] data_q;
    // sequencer
    d2dini_state_t state_q;
    logic [2:0] beat_q;
    logic [15:0] sh_q;
    logic blocking_q;
    logic [7:0] lane_d;
    logic lane_drive_d;
    logic [7:0] used;
    // link clock and timeout
    logic lclk;
    logic tick_raw;
    logic tick;
    logic tmo_clear;
    logic tmo_exp;
    logic run;
    // request decode
    logic req;
    logic start;
    logic [2:0] bpb;
    logic [1:0] ack;
    logic ack_err;
    logic par_err;

    function automatic logic [2:0] data_beats(input logic wide, input logic byte_sz);
        logic [2:0] n;
        n = wide ? 3'd1 : BEATS_NARROW;
        data_beats = byte_sz ? n : 3'(n << 1);
    endfunction : data_beats

    assign en = ctl0_q[CTL0_EN];
    assign cw = ctl0_q[CTL0_CW];
    assign bpb = cw ? 3'd1 : BEATS_NARROW;
    assign req = win_wr || win_rd;
    assign start = req && en && !busy_q;
    assign tick = tick_raw && !stop_mode;
    assign ack = link_data_in[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // link clock

    // clock halts when disabled, or in stop with halt set
    assign run = en && !(stop_mode && ctl0_q[CTL0_SWAI]);

    d2dini_clkdiv u_clkdiv (
        .clk(clk),
        .rst_n(rst_n),
        .run(run),
        .div(ctl0_q[CTL0_DIV +: 2]),
        .clk_q(lclk),
        .tick_q(tick_raw)
    );

    assign link_clock_out = lclk;

    assign tmo_clear = (state_q != D2DI_ACK);

    d2dini_tmo u_tmo (
        .clk(clk),
        .rst_n(rst_n),
        .clear(tmo_clear),
        .tick(tick),
        .limit(ctl1_q[CTL1_TMO +: 4]),
        .expired_q(tmo_exp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl0_q <= CTL0_RST;
            ctl0_locked_q <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CTL0) begin
            ctl0_q[CTL0_SWAI] <= reg_wdata[CTL0_SWAI];
            if (!ctl0_locked_q || special_mode) begin
                ctl0_q[CTL0_EN] <= reg_wdata[CTL0_EN];
                ctl0_q[CTL0_CW] <= reg_wdata[CTL0_CW];
                ctl0_q[CTL0_DIV +: 2] <= reg_wdata[CTL0_DIV +: 2];
            end
            ctl0_locked_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl1_q <= CTL1_RST;
        end else if (reg_wr && reg_addr == REG_CTL1) begin
            ctl1_q[CTL1_IE] <= reg_wdata[CTL1_IE];
            ctl1_q[CTL1_TMO +: 4] <= reg_wdata[CTL1_TMO +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, data valid in the following cycle only

    always_ff @(posedge clk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                REG_CTL0: reg_rdata <= ctl0_q;
                REG_CTL1: reg_rdata <= ctl1_q;
                REG_ERR: reg_rdata <= err_q;
                REG_IRQB: reg_rdata <= {target_irq_in, busy_q, 6'h00};
                REG_ATTR: reg_rdata <= attr_q;
                REG_ADDR: reg_rdata <= addr_q;
                REG_DHI: reg_rdata <= data_q[15:8];
                REG_DLO: reg_rdata <= data_q[7:0];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error flags: write one to clear, a new event wins over the clear

    assign ack_err = (ack == ACK_BAD);
    assign par_err = attr_q[ATTR_RNW] &&
        ((link_data_in[2] != ^sh_q[7:0]) ||
         (!attr_q[ATTR_SZ8] && link_data_in[3] != ^sh_q[15:8]));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_q <= STAT_RST;
        end else begin
            if (reg_wr && reg_addr == REG_ERR) begin
                err_q[7:2] <= err_q[7:2] & ~reg_wdata[7:2];
            end
            if (req && (!en || busy_q)) begin
                err_q[ERR_CNCL] <= 1'b1;
                err_q[ERR_SUM] <= 1'b1;
            end
            if (state_q == D2DI_ACK && tmo_exp) begin
                err_q[ERR_TIME] <= 1'b1;
                err_q[ERR_SUM] <= 1'b1;
            end
            if (state_q == D2DI_ACK && tick && ack != ACK_WAIT) begin
                err_q[1:0] <= link_data_in[3:2];
                if (ack_err) begin
                    err_q[ERR_ACK] <= 1'b1;
                    err_q[ERR_SUM] <= 1'b1;
                end else if (ack == ACK_TERR) begin
                    err_q[ERR_TERR] <= 1'b1;
                    err_q[ERR_SUM] <= 1'b1;
                end else if (par_err) begin
                    err_q[ERR_PAR] <= 1'b1;
                    err_q[ERR_SUM] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            error_irq <= 1'b0;
            target_irq_req <= 1'b0;
        end else begin
            error_irq <= err_q[ERR_SUM];
            target_irq_req <= en && ctl1_q[CTL1_IE] && target_irq_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // last transaction record

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            attr_q <= 8'h00;
            addr_q <= 8'h00;
            data_q <= 16'h0000;
        end else if (start) begin
            attr_q <= 8'h00;
            attr_q[ATTR_RNW] <= win_rd;
            attr_q[ATTR_SZ8] <= win_byte;
            attr_q[ATTR_NONBLOCKING_FLAG] <= win_nonblock;
            addr_q <= win_addr;
            data_q <= win_wr ? win_wdata : 16'h0000;
        end else if (state_q == D2DI_ACK && tick && attr_q[ATTR_RNW] && ack == ACK_OK) begin
            data_q <= attr_q[ATTR_SZ8] ? {8'h00, sh_q[7:0]} : sh_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link sequencer

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= D2DI_IDLE;
            beat_q <= 3'd0;
            sh_q <= 16'h0000;
            busy_q <= 1'b0;
            blocking_q <= 1'b0;
        end else if (!en) begin
            state_q <= D2DI_IDLE;
            busy_q <= 1'b0;
            blocking_q <= 1'b0;
        end else if (start) begin
            state_q <= D2DI_CMD;
            busy_q <= 1'b1;
            blocking_q <= win_rd || !win_nonblock;
        end else if (tick) begin
            unique case (state_q)
                D2DI_IDLE: begin
                    beat_q <= 3'd0;
                end
                D2DI_CMD: begin
                    state_q <= D2DI_ADDR;
                    sh_q <= {addr_q, 8'h00};
                    beat_q <= 3'(bpb - 3'd1);
                end
                D2DI_ADDR: begin
                    sh_q <= cw ? 16'(sh_q << 8) : 16'(sh_q << 4);
                    if (beat_q != 3'd0) begin
                        beat_q <= 3'(beat_q - 3'd1);
                    end else if (attr_q[ATTR_RNW]) begin
                        state_q <= D2DI_TURN;
                    end else begin
                        state_q <= D2DI_WDATA;
                        sh_q <= attr_q[ATTR_SZ8] ? {data_q[7:0], 8'h00} : data_q;
                        beat_q <= 3'(data_beats(cw, attr_q[ATTR_SZ8]) - 3'd1);
                    end
                end
                D2DI_WDATA: begin
                    sh_q <= cw ? 16'(sh_q << 8) : 16'(sh_q << 4);
                    if (beat_q != 3'd0) begin
                        beat_q <= 3'(beat_q - 3'd1);
                    end else begin
                        state_q <= D2DI_TURN;
                    end
                end
                D2DI_TURN: begin
                    sh_q <= 16'h0000;
                    if (attr_q[ATTR_RNW]) begin
                        state_q <= D2DI_RDATA;
                        beat_q <= 3'(data_beats(cw, attr_q[ATTR_SZ8]) - 3'd1);
                    end else begin
                        state_q <= D2DI_ACK;
                    end
                end
                D2DI_RDATA: begin
                    sh_q <= cw ? {sh_q[7:0], link_data_in} : {sh_q[11:0], link_data_in[3:0]};
                    if (beat_q != 3'd0) begin
                        beat_q <= 3'(beat_q - 3'd1);
                    end else begin
                        state_q <= D2DI_ACK;
                    end
                end
                D2DI_ACK: begin
                    if (ack != ACK_WAIT || tmo_exp) begin
                        state_q <= D2DI_IDLE;
                        busy_q <= 1'b0;
                        blocking_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= D2DI_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end else if (state_q == D2DI_ACK && tmo_exp) begin
            state_q <= D2DI_IDLE;
            busy_q <= 1'b0;
            blocking_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu side completion

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_done <= 1'b0;
            win_stall <= 1'b0;
            win_rdata <= 16'h0000;
        end else begin
            win_done <= 1'b0;
            if (req && !(start && (win_rd || !win_nonblock))) begin
                win_done <= 1'b1;
            end
            if (start) begin
                win_stall <= win_rd || !win_nonblock;
            end
            if (blocking_q && busy_q && state_q != D2DI_CMD && !(state_q == D2DI_IDLE)) begin
                if ((state_q == D2DI_ACK && tick && ack != ACK_WAIT) ||
                    (state_q == D2DI_ACK && tmo_exp) || !en) begin
                    win_done <= 1'b1;
                    win_stall <= 1'b0;
                    win_rdata <= (attr_q[ATTR_SZ8] ? {8'h00, sh_q[7:0]} : sh_q);
                end
            end
            if (!en) begin
                win_stall <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    assign used = cw ? 8'hff : 8'h0f;

    always_comb begin
        lane_d = 8'h00;
        lane_drive_d = 1'b1;
        unique case (state_q)
            D2DI_CMD: lane_d = {4'h0, attr_q[ATTR_RNW] ? CMD_RD : CMD_WR,
                                attr_q[ATTR_SZ8], attr_q[ATTR_NONBLOCKING_FLAG]};
            D2DI_ADDR, D2DI_WDATA: lane_d = cw ? sh_q[15:8] : {4'h0, sh_q[15:12]};
            D2DI_TURN, D2DI_RDATA, D2DI_ACK: lane_drive_d = 1'b0;
            default: lane_d = {4'h0, CMD_IDLE};
        endcase
        if (stop_mode) begin
            lane_d = 8'h00;
            lane_drive_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !en) begin
            link_data_out <= 8'h00;
            link_data_oe <= 8'h00;
            link_data_pd <= 8'h00;
            target_irq_pd <= 1'b0;
        end else begin
            link_data_out <= lane_d & used;
            link_data_oe <= lane_drive_d ? used : 8'h00;
            link_data_pd <= lane_drive_d ? 8'h00 : used;
            target_irq_pd <= 1'b1;
        end
    end
endmodule : d2dini_top

// ===== verif/d2dini_asserts.sv
// port checker for the die-to-die initiator
`timescale 1ns/1ps
module d2dini_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // cpu side
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic win_wr,
    input wire logic win_rd,
    input wire logic win_nonblock,
    input wire logic win_done,
    input wire logic win_stall,
    input wire logic stop_mode,
    input wire logic error_irq,
    // link side
    input wire logic link_clock_out,
    input wire logic [7:0] link_data_out,
    input wire logic [7:0] link_data_oe,
    input wire logic [7:0] link_data_pd,
    input wire logic target_irq_in,
    input wire logic target_irq_pd,
    input wire logic target_irq_req
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    a_pd_input: assert property ((link_data_pd & link_data_oe) == 8'h00)
        else $error("pull-down on driven line");
    a_pd_lower: assert property (target_irq_pd |-> link_data_pd[3:0] == ~link_data_oe[3:0])
        else $error("pull-down missing on input line");
    a_req_cause: assert property (target_irq_req |-> target_irq_pd && $past(target_irq_in))
        else $error("target request without cause");
    a_nb_done: assert property (win_wr && win_nonblock |=> win_done && !win_stall)
        else $error("non-blocking write not done at once");
    a_blk_stall: assert property ((win_wr || win_rd) && !win_nonblock |=> win_done != win_stall)
        else $error("blocking access neither stalled nor done");
    a_stall_end: assert property ($fell(win_stall) |-> win_done || $past(win_done))
        else $error("stall ended without done");
    a_high_short: assert property (link_clock_out && $past(link_clock_out) |=> !link_clock_out)
        else $error("link clock high too long");
    a_clk_runs: assert property (not ((target_irq_pd && !stop_mode && !link_clock_out)[*6]))
        else $error("link clock stopped while enabled");
    a_off_quiet: assert property ((!target_irq_pd)[*3] |-> !link_clock_out && link_data_oe == 8'h00)
        else $error("link active while disabled");
    a_stop_low: assert property (stop_mode[*3] |-> (link_data_out & link_data_oe) == 8'h00)
        else $error("data high in stop");
    a_err_done: assert property ($rose(error_irq) |-> (win_done || $past(win_done)) or ##[1:2] win_done)
        else $error("error interrupt apart from access end");
    c_blocking: cover property ($fell(win_stall));
    c_error: cover property ($rose(error_irq));
    c_target_irq: cover property (target_irq_req);
endmodule : d2dini_asserts

bind d2dini_top d2dini_asserts u_asserts (.*);

// ===== verif/d2dini_target.sv
// behavioural target die answering each released slot with a scripted code
`timescale 1ns/1ps
module d2dini_target (
    // link pins
    input wire logic link_clock_out,
    input wire logic line_dir,
    // scenario control
    input wire logic [3:0] ack_code,
    input wire logic [3:0] wait_n,
    // reply on the lower lines
    output logic [3:0] tgt_data
);
    logic [3:0] cnt_q;
    // link clocks since the initiator released the lines
    always_ff @(posedge link_clock_out) begin
        cnt_q <= line_dir ? 4'h0 : cnt_q + 4'(cnt_q != 4'hf);
    end
    // wait beats first, then ack_code on every later beat, as data nibbles, ack and parity bits
    assign tgt_data = (cnt_q >= wait_n) ? ack_code : 4'h0;
endmodule : d2dini_target

// ===== verif/tb.sv
// self-checking bench for the die-to-die initiator
`timescale 1ns/1ps
module tb
    import d2dini_pkg::*;
;
    logic clk, rst_n, reg_wr, reg_rd, win_wr, win_rd, win_nonblock, win_byte, special_mode;
    logic stop_mode, target_irq_in, win_done, win_stall, link_clock_out, target_irq_pd;
    logic target_irq_req, error_irq, en, wide;
    logic [2:0] reg_addr;
    logic [3:0] ack_code, wait_n, tgt_data;
    logic [7:0] reg_wdata, reg_rdata, win_addr, link_data_out, link_data_oe, link_data_pd;
    logic [7:0] link_data_in, v;
    logic [15:0] win_wdata, win_rdata;
    logic [7:0] beats[$];
    int fail_count, n_tests, i;

    d2dini_top dut (.*);
    d2dini_target u_tgt (
        .link_clock_out(link_clock_out),
        .line_dir(link_data_oe[0]),
        .ack_code(ack_code),
        .wait_n(wait_n),
        .tgt_data(tgt_data)
    );
    // released lines fall to their pull-downs unless the target drives them
    assign link_data_in = (link_data_out & link_data_oe) | (~link_data_oe & {4'h0, tgt_data});

    always #4 clk = ~clk;
    always @(negedge link_clock_out) begin
        if (link_data_oe[0] && (beats.size() > 0 || link_data_out[3])) begin
            beats.push_back(link_data_out);
        end
    end
    ////////////////////////////////////////
    task complete_run;
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task rdc(input logic [2:0] a, input logic [7:0] e);
        rd(a, v);
        chk(v, e);
    endtask : rdc

    task automatic per(input int p);
        time t0;
        repeat (2) @(posedge link_clock_out);
        t0 = $time;
        @(negedge link_clock_out);
        chk(16'(($time - t0) / 8), 16'(p / 2));
        @(posedge link_clock_out);
        chk(16'(($time - t0) / 8), 16'(p));
    endtask : per

    task automatic win(input logic w, nb, by, input logic [15:0] d);
        logic [7:0] e[$];
        logic [7:0] m;
        int k;
        m = wide ? 8'hff : 8'h0f;
        e.push_back({5'h01, !w, by, nb});
        if (!wide) e.push_back(8'h05);
        e.push_back(wide ? 8'h5a : 8'h0a);
        for (k = w ? (by ? 1 : 2) * (wide ? 1 : 2) - 1 : -1; k >= 0; k--) begin
            e.push_back(8'(d >> (k * (wide ? 8 : 4))) & m);
        end
        beats.delete();
        @(posedge clk);
        {win_wr, win_rd, win_nonblock, win_byte, win_wdata} <= {w, !w, nb, by, d};
        @(posedge clk);
        {win_wr, win_rd} <= 2'b00;
        #1;
        chk(win_stall, !nb && en);
        for (k = 0; k < 500 && win_done !== 1'b1; k++) @(posedge clk) #1;
        chk(win_done, 1'b1);
        if (nb) begin
            rd(REG_IRQB, v);
            chk(v[6], en);
            for (k = 0; k < 500 && v[6]; k++) rd(REG_IRQB, v);
        end
        for (k = 0; en && k < e.size(); k++) chk(beats[k] & (k ? m : 8'h0f), e[k]);
    endtask : win

    task xfer(input logic w, nb, by, input logic [15:0] d, input logic [3:0] c, t,
              input logic [7:0] err, msk);
        {ack_code, wait_n} <= {c, t};
        win(w, nb, by, d);
        if (!w) chk(win_rdata, {c, c, c, c} & (by ? 16'h00ff : 16'hffff));
        rd(REG_ERR, v);
        chk(v & msk, err);
        chk(error_irq, err != 8'h00);
        rdc(REG_ATTR, {!w, by, 1'b0, nb, 4'h0});
        rdc(REG_ADDR, 8'h5a);
        wr(REG_ERR, 8'hfc);
        rd(REG_ERR, v);
        chk(v & 8'hfc, 8'h00);
    endtask : xfer
    ////////////////////////////////////////
    initial begin
        #300000;
        fail_count++;
        complete_run;
    end

    initial begin
        clk = 1'b0;
        {rst_n, reg_wr, reg_rd, win_wr, win_rd, win_nonblock, win_byte, special_mode} = '0;
        {stop_mode, target_irq_in, en, wide, reg_addr, reg_wdata, win_wdata, wait_n} = '0;
        {fail_count, n_tests} = '0;
        win_addr = 8'h5a;
        ack_code = 4'h1;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) rdc(3'(i), 8'h00);
        win(1'b1, 1'b1, 1'b1, 16'h0033);
        rdc(REG_ERR, 8'ha0);
        chk(error_irq, 1'b1);
        wr(REG_ERR, 8'hfc);
        rdc(REG_ERR, 8'h00);
        wr(REG_CTL0, 8'h81);
        en = 1'b1;
        rdc(REG_CTL0, 8'h81);
        chk({link_data_oe, link_data_out}, 16'h0f00);
        chk(target_irq_pd, 1'b1);
        wr(REG_CTL0, 8'hc3);
        rdc(REG_CTL0, 8'h81);
        per(2);
        special_mode <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(REG_CTL0, 8'h80 | 8'(i));
            rdc(REG_CTL0, 8'h80 | 8'(i));
            per(i < 1 ? 2 : i + 1);
        end
        wr(REG_CTL0, 8'h81);
        xfer(1'b1, 1'b1, 1'b1, 16'h00c7, 4'h1, 4'h0, 8'h00, 8'hfc);
        xfer(1'b1, 1'b0, 1'b0, 16'h9be4, 4'h1, 4'h5, 8'h00, 8'hfc);
        xfer(1'b0, 1'b0, 1'b0, 16'h0000, 4'h1, 4'h0, 8'h00, 8'hff);
        xfer(1'b0, 1'b0, 1'b1, 16'h0000, 4'h5, 4'h0, 8'h85, 8'hff);
        xfer(1'b1, 1'b0, 1'b0, 16'h1234, 4'h2, 4'h0, 8'h88, 8'hfc);
        xfer(1'b1, 1'b0, 1'b1, 16'h0011, 4'h3, 4'h0, 8'hc0, 8'hfc);
        wr(REG_CTL1, 8'h04);
        xfer(1'b1, 1'b0, 1'b1, 16'h0022, 4'h0, 4'h0, 8'h90, 8'h90);
        wr(REG_CTL1, 8'h80);
        target_irq_in <= 1'b1;
        rdc(REG_IRQB, 8'h80);
        chk(target_irq_req, 1'b1);
        wr(REG_CTL1, 8'h00);
        rdc(REG_IRQB, 8'h80);
        chk(target_irq_req, 1'b0);
        target_irq_in <= 1'b0;
        wr(REG_CTL0, 8'ha1);
        stop_mode <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk({link_clock_out, link_data_out & link_data_oe}, 16'h0000);
        stop_mode <= 1'b0;
        per(2);
        #1;
        chk(link_data_out, 8'h00);
        wr(REG_CTL0, 8'hc1);
        wide = 1'b1;
        rdc(REG_CTL0, 8'hc1);
        chk(link_data_oe, 8'hff);
        xfer(1'b1, 1'b0, 1'b0, 16'h5ac3, 4'h1, 4'h0, 8'h00, 8'hfc);
        wr(REG_CTL0, 8'h01);
        en = 1'b0;
        rdc(REG_CTL0, 8'h01);
        repeat (4) @(posedge clk);
        #1;
        chk({link_clock_out, link_data_oe}, 16'h0000);
        complete_run;
    end
endmodule : tb
